// ==== tb/cvd2_ctrl_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module cvd2_ctrl_checker
  import cvd2_pkg::*;
(
  input wire logic        clk_sys,    // Clock
  input wire logic        rstn,       // Reset
  input wire logic        wb_cyc_i,   // Cycle
  input wire logic        wb_stb_i,   // Strobe
  input wire logic        wb_we_i,    // Write
  input wire logic [7:0]  wb_adr_i,   // Address
  input wire logic [3:0]  wb_sel_i,   // Lanes
  input wire logic [31:0] wb_dat_i,   // Data in
  input wire logic        wb_ack_o,   // Ack
  input wire logic        convStart,  // Start
  input wire logic        convAbort,  // Abort
  input wire logic        muxConnect, // Mux on
  input wire logic [4:0]  muxChannel, // Channel
  input wire logic [1:0]  refLevel,   // Level
  input wire logic [4:0]  extraCapPf  // Cap pF
);
  // Write takes per register, with the fields they carry
  wire       wrTake = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
  wire       ctrlWr = wrTake && wb_adr_i == CONV_CTRL_OFS;
  wire       refWr  = wrTake && wb_adr_i == REF_CTRL_OFS;
  wire       capWr  = wrTake && wb_adr_i == CAP_SEL_OFS;
  wire       goEn   = wb_dat_i[GO_BIT] && wb_dat_i[ENABLE_BIT];
  wire [1:0] gainIn = wb_dat_i[1:0];
  wire [3:0] capIn  = wb_dat_i[3:0];

  function automatic logic [1:0] lv(input logic [1:0] g);
    return (g == 2'h1 || g == 2'h2) ? g : 2'h0;
  endfunction

  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  // One wait state, ack for one cycle only
  property p_ackNext;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ackNext: assert property (p_ackNext) else $error("ack timing");
  property p_refLevel;
    refWr |-> ##2 refLevel == lv($past(gainIn, 2));
  endproperty
  a_refLevel: assert property (p_refLevel) else $error("gain level");
  // Reserved codes must never connect
  property p_muxLegal;
    muxConnect |-> muxChannel <= 5'h02 || (muxChannel >= 5'h14 && muxChannel <= 5'h1B)
      || muxChannel == 5'h1D || muxChannel == 5'h1F;
  endproperty
  a_muxLegal: assert property (p_muxLegal) else $error("reserved channel");
  property p_muxOff;
    ctrlWr && !wb_dat_i[ENABLE_BIT] |-> ##2 !muxConnect [*3];
  endproperty
  a_muxOff: assert property (p_muxOff) else $error("mux on while off");
  property p_cap;
    capWr |-> ##2 extraCapPf == {$past(capIn, 2), 1'b0};
  endproperty
  a_cap: assert property (p_cap) else $error("cap value");
  // Abort only from a control write that drops go or enable
  property p_abortCause;
    convAbort |-> $past(ctrlWr) && !$past(goEn);
  endproperty
  a_abortCause: assert property (p_abortCause) else $error("stray abort");
  property p_abortSolo;
    convAbort |-> !convStart ##1 !convStart;
  endproperty
  a_abortSolo: assert property (p_abortSolo) else $error("start on abort");
  property p_noStart;
    ctrlWr && wb_dat_i[1:0] == 2'b10 |=> !convStart [*4];
  endproperty
  a_noStart: assert property (p_noStart) else $error("start while off");

  c_start: cover property (convStart);
  c_abort: cover property (convAbort);
  c_temp: cover property (muxConnect && muxChannel == 5'h1D);
endmodule

bind cvd2_ctrl cvd2_ctrl_checker u_chk
(
  .clk_sys, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_ack_o, .convStart, .convAbort, .muxConnect, .muxChannel,
  .refLevel, .extraCapPf
);
`default_nettype wire

// ==== tb/cvd_adc2_control_regs_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module cvd_adc2_control_regs_bench
  import cvd2_pkg::*;
;
  logic        clk_sys, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
  logic        refReadyIn, convDone, convStart, convAbort, muxConnect;
  logic        refEnable, tempEnable, tempRange;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, v;
  logic [9:0]  convData;
  logic [4:0]  muxChannel, extraCapPf;
  logic [1:0]  refLevel;
  int          errors = 0, samples_checked = 0, nStart = 0, nAbort = 0;
  int          n, i, seed;

  // Short instruction cycle keeps the clock-select wait brief
  cvd2_ctrl #(.INSTR(2)) DUT
  (
    .clk_sys, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .refReadyIn, .convDone, .convData,
    .convStart, .convAbort, .muxConnect, .muxChannel, .refLevel, .refEnable,
    .tempEnable, .tempRange, .extraCapPf
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Pulse counts by NBA, so reads at an edge see the old count
  always @(posedge clk_sys)
  begin
    nStart <= nStart + int'(convStart === 1'b1);
    nAbort <= nAbort + int'(convAbort === 1'b1);
  end

  function automatic logic legal(input logic [4:0] c);
    return c <= 5'h02 || (c >= 5'h14 && c <= 5'h1B) || c == 5'h1D || c == 5'h1F;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("errors %0d checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Classic cycle: hold until ack is sampled, take data there
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    logic ackSeen;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 20);
    ackSeen = (wb_ack_o === 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
    if (!ackSeen)
    begin
      chk(32'h0, 32'h1);
      results();
    end
  endtask

  // Converter finishes with the given data
  task automatic pulse(input logic [9:0] d);
    convData <= d;
    convDone <= 1'b1;
    @(posedge clk_sys);
    convDone <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask

  initial
  begin
    seed = 32'h0B07;
    {rstn, wb_cyc_i, wb_stb_i, wb_we_i, refReadyIn, convDone} = 6'h00;
    {wb_adr_i, wb_dat_i, convData} = '0;
    wb_sel_i = 4'h1;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    // Reset values, plus one unmapped place
    for (i = 0; i <= 28; i += 4)
    begin
      bus(1'b0, 8'(i), 8'h00);
      chk(rd, 32'h0);
    end
    bus(1'b1, 8'h1C, 8'hFF);
    bus(1'b0, 8'h1C, 8'h00);
    chk(rd, 32'h0);
    // Every gain code, random control bits and ready input
    for (i = 0; i < 4; i++)
    begin
      v = $random(seed);
      refReadyIn <= v[8];
      bus(1'b1, REF_CTRL_OFS, {v[7], 1'b0, v[5:4], 2'b00, 2'(i)});
      chk(refLevel, (i == 1 || i == 2) ? i : 0);
      chk({refEnable, tempEnable, tempRange}, {v[7], v[5:4]});
      bus(1'b0, REF_CTRL_OFS, 8'h00);
      chk(rd, {v[7], v[8] & v[7], v[5:4], 2'b00, 2'(i)});
    end
    for (i = 0; i < 16; i++)
    begin
      bus(1'b1, CAP_SEL_OFS, {4'hF, 4'(i)});
      chk(extraCapPf, 2 * i);
      bus(1'b0, CAP_SEL_OFS, 8'h00);
      chk(rd, i);
    end
    // Lane 0 off: write ignored
    wb_sel_i <= 4'hE;
    bus(1'b1, CAP_SEL_OFS, 8'h05);
    wb_sel_i <= 4'h1;
    bus(1'b0, CAP_SEL_OFS, 8'h00);
    chk(rd, 32'hF);
    for (i = 0; i < 32; i++)
    begin
      bus(1'b1, CONV_CTRL_OFS, {1'b0, 5'(i), 2'b01});
      chk(muxConnect, legal(5'(i)));
      chk(muxChannel, i);
    end
    // Go with the converter off starts nothing
    bus(1'b1, CONV_CTRL_OFS, 8'h7E);
    chk(muxConnect, 1'b0);
    bus(1'b0, CONV_CTRL_OFS, 8'h00);
    chk(rd, 32'h7C);
    chk(nStart, 0);
    bus(1'b1, IRQ_MASK_OFS, 8'h03);
    // Modes: double sample in bit 0, slow clock in bit 1
    for (i = 0; i < 4; i++)
    begin
      bus(1'b1, MODE_OFS, 8'(i));
      n = nStart;
      bus(1'b1, CONV_CTRL_OFS, 8'h7F);
      chk(nStart, n + int'(i < 2));
      repeat (6) @(posedge clk_sys);
      chk(nStart, n + 1);
      v = $random(seed);
      pulse(v[9:0]);
      if (i % 2 == 1)
      begin
        chk(nStart, n + 2);
        bus(1'b0, CONV_CTRL_OFS, 8'h00);
        chk(rd, 32'h7F);
        v = $random(seed);
        pulse(v[9:0]);
      end
      chk(irq, 1'b1);
      bus(1'b0, CONV_CTRL_OFS, 8'h00);
      chk(rd, 32'h7D);
      bus(1'b0, RESULT_OFS, 8'h00);
      chk(rd, v[9:0]);
      bus(1'b0, IRQ_STAT_OFS, 8'h00);
      chk(rd, 32'h1);
      @(posedge clk_sys);
      chk(irq, 1'b0);
    end
    // Abort mid-conversion with its event masked
    bus(1'b1, MODE_OFS, 8'h00);
    bus(1'b1, IRQ_MASK_OFS, 8'h01);
    bus(1'b1, CONV_CTRL_OFS, 8'h7F);
    v = $random(seed);
    convData <= v[9:0];
    bus(1'b1, CONV_CTRL_OFS, 8'h7D);
    chk(nAbort, 1);
    chk(irq, 1'b0);
    bus(1'b0, RESULT_OFS, 8'h00);
    chk(rd, v[9:0]);
    bus(1'b1, IRQ_MASK_OFS, 8'h03);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b1);
    bus(1'b0, IRQ_STAT_OFS, 8'h00);
    chk(rd, 32'h2);
    // Mid-run reset brings outputs and registers back to zero
    rstn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk({muxConnect, muxChannel, refLevel, extraCapPf}, 32'h0);
    bus(1'b0, CONV_CTRL_OFS, 8'h00);
    chk(rd, 32'h0);
    bus(1'b0, CAP_SEL_OFS, 8'h00);
    chk(rd, 32'h0);
    results();
  end
endmodule
`default_nettype wire

// ==== verilog/cvd2_ctrl.sv ====
// Notes on behaviour
// R01 - Reference gain code 01 gives 1.024V, 10 gives 2.048V, and 00 or 11 turn the output off.
// R02 - Channel bits 6..2 pick inputs 0-2, 20-26, positive ref, temp or buffer; others reserved.
// R03 - With the converter disabled every multiplexer input is disconnected.
// R04 - Setting status while enabled starts a conversion; on RC clock it waits an instruction.
// R05 - Hardware clears the status bit when the conversion completes.
// R06 - Clearing the status bit mid-conversion stops it, keeps the partial result, no done flag.
// R07 - With double sampling the status bit clears only after the second conversion.
// R08 - The 4-bit extra capacitor code adds 2pF a step, code 0000 off, 30pF at the top.
// R09 - While disabled the status bit reads zero and a set of it starts nothing.
`timescale 1ns/1ps
`default_nettype none
module cvd2_ctrl
  import cvd2_pkg::*;
#(
  parameter int RES_W = 10,
  parameter int INSTR = INSTR_CLKS
)
(
  input  wire logic             clk_sys,      // System clock, 100 MHz
  input  wire logic             rstn,         // Asynchronous reset, active low
  input  wire logic             wb_cyc_i,     // Wishbone cycle
  input  wire logic             wb_stb_i,     // Wishbone strobe
  input  wire logic             wb_we_i,      // Wishbone write
  input  wire logic [7:0]       wb_adr_i,     // Byte address
  input  wire logic [3:0]       wb_sel_i,     // Byte lanes
  input  wire logic [31:0]      wb_dat_i,     // Write data
  output logic      [31:0]      wb_dat_o,     // Read data
  output logic                  wb_ack_o,     // Acknowledge
  output logic                  irq,          // Level interrupt
  input  wire logic             refReadyIn,   // Reference ready from analog
  input  wire logic             convDone,     // Converter finished a conversion
  input  wire logic [RES_W-1:0] convData,     // Converter data, partial on abort
  output logic                  convStart,    // Pulse: begin a conversion
  output logic                  convAbort,    // Pulse: stop the conversion
  output logic                  muxConnect,   // Channel multiplexer connected
  output logic      [4:0]       muxChannel,   // Selected channel code
  output logic      [1:0]       refLevel,     // 0 off, 1 = 1x, 2 = 2x
  output logic                  refEnable,    // Reference enable
  output logic                  tempEnable,   // Temperature indicator enable
  output logic                  tempRange,    // Temperature range select
  output logic      [4:0]       extraCapPf    // Extra sample cap in pF
);

  logic                rstnSync;
  logic                instrTick;
  logic [7:0]          refCtrlQ;
  logic [4:0]          chanQ;
  logic                conv2EnableQ;
  logic                goQ;
  logic [3:0]          capCodeQ;
  logic                dsenQ;
  logic                rcSelQ;
  logic [1:0]          evtQ;
  logic [1:0]          maskQ;
  logic [RES_W-1:0]    resultQ;
  cvd2_seq_type        seqQ;
  logic                access;
  logic                wrEn;
  logic                rdEn;
  logic                wrCtrl;
  logic                startReq;
  logic                abortReq;
  logic                busy;
  logic                lastDone;
  logic [31:0]         rdData;
  logic                wrRef;
  logic                wrCap;
  logic                wrMode;
  logic                wrMask;
  logic                rdStat;

  cvd2_reset_sync uRst
  (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .rstnSync (rstnSync)
  );

  cvd2_tick_div #(.DIV(INSTR)) uTick
  (
    .clk_sys (clk_sys),
    .rstn    (rstnSync),
    .tick    (instrTick)
  );

  // Bus decode; a request is taken in the cycle before ack
  assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wrEn   = access && wb_we_i && wb_sel_i[0];
  assign rdEn   = access && !wb_we_i;
  assign wrCtrl = wrEn && (wb_adr_i == CONV_CTRL_OFS);

  // Per-register strobes, shared by the store and clear paths
  assign wrRef  = wrEn && (wb_adr_i == REF_CTRL_OFS);
  assign wrCap  = wrEn && (wb_adr_i == CAP_SEL_OFS);
  assign wrMode = wrEn && (wb_adr_i == MODE_OFS);
  assign wrMask = wrEn && (wb_adr_i == IRQ_MASK_OFS);
  assign rdStat = rdEn && (wb_adr_i == IRQ_STAT_OFS);

  // Start needs the enable written in the same word
  assign busy     = (seqQ != SEQ_IDLE);
  assign startReq = wrCtrl && wb_dat_i[GO_BIT] && wb_dat_i[ENABLE_BIT] && !busy; // R04 R09
  // Clearing go or enable while running stops the conversion
  assign abortReq = busy && wrCtrl
    && (!wb_dat_i[GO_BIT] || !wb_dat_i[ENABLE_BIT]); // R06
  // Final conversion of the sequence
  assign lastDone = convDone
    && ((seqQ == SEQ_SECOND) || (seqQ == SEQ_FIRST && !dsenQ)); // R07

  // Wishbone ack, one wait state, dropped the cycle after
  always_ff @(posedge clk_sys or negedge rstnSync)
  begin
    if (!rstnSync)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= access;
  end

  // Read multiplexer; unmapped offsets read zero
  always_comb
  begin
    rdData = '0;
    unique case (wb_adr_i)
      REF_CTRL_OFS:
      begin
        rdData[7:0] = refCtrlQ;
        rdData[REF_RDY_BIT] = refReadyIn && refCtrlQ[REF_EN_BIT];
      end
      CONV_CTRL_OFS:
      begin
        rdData[CHAN_LSB +: 5] = chanQ;                 // R02
        rdData[GO_BIT]        = goQ && conv2EnableQ;   // R09
        rdData[ENABLE_BIT]    = conv2EnableQ;
      end
      CAP_SEL_OFS:  rdData[3:0] = capCodeQ;
      MODE_OFS:
      begin
        rdData[DSEN_BIT]  = dsenQ;
        rdData[RCSEL_BIT] = rcSelQ;
      end
      IRQ_STAT_OFS: rdData[1:0] = evtQ;
      IRQ_MASK_OFS: rdData[1:0] = maskQ;
      RESULT_OFS:   rdData[RES_W-1:0] = resultQ;
      default:      rdData = '0;
    endcase
  end

  // Read data registered alongside ack
  always_ff @(posedge clk_sys or negedge rstnSync)
  begin
    if (!rstnSync)
      wb_dat_o <= '0;
    else if (rdEn)
      wb_dat_o <= rdData;
  end

  // Fixed reference control; ready bit is never stored
  always_ff @(posedge clk_sys or negedge rstnSync)
  begin
    if (!rstnSync)
      refCtrlQ <= REG_RESET;
    else if (wrRef)
    begin
      refCtrlQ <= wb_dat_i[7:0];
      refCtrlQ[REF_RDY_BIT] <= 1'b0;
      refCtrlQ[3:2] <= 2'b00;
    end
  end

  // Channel and enable fields
  always_ff @(posedge clk_sys or negedge rstnSync)
  begin
    if (!rstnSync)
    begin
      chanQ        <= REG_RESET[4:0];
      conv2EnableQ <= 1'b0;
    end
    else if (wrCtrl)
    begin
      chanQ        <= wb_dat_i[CHAN_LSB +: 5]; // R02
      conv2EnableQ <= wb_dat_i[ENABLE_BIT];
    end
  end

  // Status bit: set by a start, cleared by hardware at the end
  always_ff @(posedge clk_sys or negedge rstnSync)
  begin
    if (!rstnSync)
      goQ <= 1'b0;
    else if (startReq)
      goQ <= 1'b1;                             // R04
    else if (abortReq)
      goQ <= 1'b0;                             // R06
    else if (busy && lastDone)
      goQ <= 1'b0;                             // R05 R07
    else if (!busy)
      goQ <= 1'b0;                             // R09
  end

  // Capacitor code and mode bits
  always_ff @(posedge clk_sys or negedge rstnSync)
  begin
    if (!rstnSync)
    begin
      capCodeQ <= REG_RESET[3:0];
      dsenQ    <= 1'b0;
      rcSelQ   <= 1'b0;
    end
    else
    begin
      if (wrCap)
        capCodeQ <= wb_dat_i[3:0];             // R08
      if (wrMode)
      begin
        dsenQ  <= wb_dat_i[DSEN_BIT];
        rcSelQ <= wb_dat_i[RCSEL_BIT];
      end
    end
  end

  // Mask register
  always_ff @(posedge clk_sys or negedge rstnSync)
  begin
    if (!rstnSync)
      maskQ <= EVT_RESET;
    else if (wrMask)
      maskQ <= wb_dat_i[1:0];
  end

  // Conversion sequencer
  always_ff @(posedge clk_sys or negedge rstnSync)
  begin
    if (!rstnSync)
      seqQ <= SEQ_IDLE;
    else if (abortReq)
      seqQ <= SEQ_IDLE;                        // R06
    else
    begin
      unique case (seqQ)
        SEQ_IDLE:
          if (startReq)
            seqQ <= rcSelQ ? SEQ_RC_WAIT : SEQ_FIRST; // R04
        SEQ_RC_WAIT:
          if (instrTick)
            seqQ <= SEQ_FIRST;                 // R04
        SEQ_FIRST:
          if (convDone)
            seqQ <= dsenQ ? SEQ_SECOND : SEQ_IDLE; // R07
        SEQ_SECOND:
          if (convDone)
            seqQ <= SEQ_IDLE;
        default:
          seqQ <= SEQ_IDLE;
      endcase
    end
  end

  // Converter strobes; second start follows the first done
  always_ff @(posedge clk_sys or negedge rstnSync)
  begin
    if (!rstnSync)
    begin
      convStart <= 1'b0;
      convAbort <= 1'b0;
    end
    else
    begin
      convStart <= !abortReq
        && ((startReq && !rcSelQ)
        || (seqQ == SEQ_RC_WAIT && instrTick)
        || (seqQ == SEQ_FIRST && convDone && dsenQ)); // R04 R07
      convAbort <= abortReq;                   // R06
    end
  end

  // Result transfer, also taken on abort as a partial value
  always_ff @(posedge clk_sys or negedge rstnSync)
  begin
    if (!rstnSync)
      resultQ <= '0;
    else if ((busy && convDone) || abortReq)
      resultQ <= convData;                     // R06
  end

  // Sticky events; a new event beats the read clear
  always_ff @(posedge clk_sys or negedge rstnSync)
  begin
    if (!rstnSync)
      evtQ <= EVT_RESET;
    else
    begin
      if (rdStat)
        evtQ <= EVT_RESET;
      if (busy && lastDone && !abortReq)
        evtQ[EVT_DONE_BIT] <= 1'b1;            // R05
      if (abortReq)
        evtQ[EVT_ABORT_BIT] <= 1'b1;           // R06
    end
  end

  // Interrupt level from a flop
  always_ff @(posedge clk_sys or negedge rstnSync)
  begin
    if (!rstnSync)
      irq <= 1'b0;
    else
      irq <= |(evtQ & maskQ);
  end

  // Multiplexer controls; a reserved channel stays disconnected
  always_ff @(posedge clk_sys or negedge rstnSync)
  begin
    if (!rstnSync)
    begin
      muxConnect <= 1'b0;
      muxChannel <= '0;
    end
    else
    begin
      muxConnect <= conv2EnableQ && chanLegal(chanQ);      // R03 R02
      muxChannel <= conv2EnableQ ? chanQ : 5'h00;          // R03
    end
  end

  // Reference and temperature controls, one cycle behind the register
  always_ff @(posedge clk_sys or negedge rstnSync)
  begin
    if (!rstnSync)
    begin
      refLevel   <= GAIN_OFF0;
      refEnable  <= 1'b0;
      tempEnable <= 1'b0;
      tempRange  <= 1'b0;
    end
    else
    begin
      refLevel   <= gainLevel(refCtrlQ[GAIN_LSB +: 2]);    // R01
      refEnable  <= refCtrlQ[REF_EN_BIT];
      tempEnable <= refCtrlQ[TEMP_EN_BIT];
      tempRange  <= refCtrlQ[TEMP_RNG_BIT];
    end
  end

  // Extra capacitor in pF; the top code still fits five bits
  always_ff @(posedge clk_sys or negedge rstnSync)
  begin
    if (!rstnSync)
      extraCapPf <= '0;
    else
      extraCapPf <= 5'(capCodeQ * CAP_STEP_PF);            // R08
  end

endmodule
`default_nettype wire

// ==== verilog/cvd2_pkg.sv ====
package cvd2_pkg;

  // Register byte offsets
  localparam logic [7:0] REF_CTRL_OFS  = 8'h00; // fixed_reference_control
  localparam logic [7:0] CONV_CTRL_OFS = 8'h04; // converter2_control_zero
  localparam logic [7:0] CAP_SEL_OFS   = 8'h08; // extra_sample_cap_select
  localparam logic [7:0] MODE_OFS      = 8'h0C; // double sample, RC clock
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h10; // sticky events, read clears
  localparam logic [7:0] IRQ_MASK_OFS  = 8'h14; // interrupt mask
  localparam logic [7:0] RESULT_OFS    = 8'h18; // last transferred result

  // Field positions
  localparam int REF_EN_BIT     = 7;
  localparam int REF_RDY_BIT    = 6;
  localparam int TEMP_EN_BIT    = 5;
  localparam int TEMP_RNG_BIT   = 4;
  localparam int GAIN_LSB       = 0;
  localparam int CHAN_LSB       = 2;
  localparam int GO_BIT         = 1;
  localparam int ENABLE_BIT     = 0;
  localparam int DSEN_BIT       = 0;
  localparam int RCSEL_BIT      = 1;
  localparam int EVT_DONE_BIT   = 0;
  localparam int EVT_ABORT_BIT  = 1;

  // Values after reset
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [1:0] EVT_RESET    = 2'h0;

  // Gain codes
  localparam logic [1:0] GAIN_OFF0 = 2'h0;
  localparam logic [1:0] GAIN_X1   = 2'h1; // 1.024V
  localparam logic [1:0] GAIN_X2   = 2'h2; // 2.048V
  localparam logic [1:0] GAIN_OFF3 = 2'h3;

  // Channel codes
  localparam logic [4:0] CH_LAST_LOW  = 5'h02;
  localparam logic [4:0] CH_FIRST_HI  = 5'h14;
  localparam logic [4:0] CH_LAST_HI   = 5'h1A;
  localparam logic [4:0] CH_POS_REF   = 5'h1B;
  localparam logic [4:0] CH_TEMP      = 5'h1D;
  localparam logic [4:0] CH_FIXED_REF = 5'h1F;

  // Extra capacitor step in pF
  localparam int CAP_STEP_PF = 2;

  // Instruction cycle: four system clocks per instruction
  localparam int INSTR_CLKS = 4;

  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_RC_WAIT,
    SEQ_FIRST,
    SEQ_SECOND
  } cvd2_seq_type;

  // Legal channel codes
  function automatic logic chanLegal(input logic [4:0] code);
    chanLegal = (code <= CH_LAST_LOW)
      || (code >= CH_FIRST_HI && code <= CH_LAST_HI)
      || (code == CH_POS_REF) || (code == CH_TEMP) || (code == CH_FIXED_REF);
  endfunction

  // Gain code to output level code, off maps to zero
  function automatic logic [1:0] gainLevel(input logic [1:0] code);
    gainLevel = (code == GAIN_X1 || code == GAIN_X2) ? code : GAIN_OFF0;
  endfunction

endpackage

// ==== verilog/cvd2_reset_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module cvd2_reset_sync
(
  input  wire logic clk_sys,  // System clock
  input  wire logic rstn,     // Asynchronous reset, active low
  output logic      rstnSync  // Released after two edges
);

  logic stage1Q;

  // Two flops so release never lands near an edge
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      stage1Q  <= 1'b0;
      rstnSync <= 1'b0;
    end
    else
    begin
      stage1Q  <= 1'b1;
      rstnSync <= stage1Q;
    end
  end

endmodule
`default_nettype wire

// ==== verilog/cvd2_tick_div.sv ====
`timescale 1ns/1ps
`default_nettype none
module cvd2_tick_div
#(
  parameter int DIV = 4
)
(
  input  wire logic clk_sys,  // System clock
  input  wire logic rstn,     // Synchronised reset, active low
  output logic      tick      // One-cycle pulse every DIV clocks
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] countQ;

  // Free running instruction-cycle divider
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      countQ <= '0;
      tick   <= 1'b0;
    end
    else
    begin
      countQ <= (countQ == LAST) ? '0 : countQ + 1'b1;
      tick   <= (countQ == LAST);
    end
  end

endmodule
`default_nettype wire
